//--- src/spm_link_if.sv
// serial link between the port and its partner
// assumes: unresolved pins idle high, as with a pull-up
`timescale 1ns/1ns
`default_nettype none
interface spm_link_if;
    logic dev_sck, dev_sck_oe, dev_mosi, dev_mosi_oe;
    logic dev_ss_n, dev_ss_oe, dev_miso, dev_miso_oe;
    logic peer_sck, peer_sck_oe, peer_mosi, peer_mosi_oe;
    logic peer_ss_n, peer_ss_oe, peer_miso, peer_miso_oe;
    logic sck, mosi, miso, ss_n;
    // ------------------------------------------------------------
    // wire levels from the enables
    // ------------------------------------------------------------
    assign sck = dev_sck_oe ? dev_sck : (peer_sck_oe ? peer_sck : 1'b1);
    assign mosi = dev_mosi_oe ? dev_mosi : (peer_mosi_oe ? peer_mosi : 1'b1);
    assign miso = dev_miso_oe ? dev_miso : (peer_miso_oe ? peer_miso : 1'b1);
    assign ss_n = dev_ss_oe ? dev_ss_n : (peer_ss_oe ? peer_ss_n : 1'b1);
    modport dev (
        output dev_sck, dev_sck_oe, dev_mosi, dev_mosi_oe,
        output dev_ss_n, dev_ss_oe, dev_miso, dev_miso_oe,
        input sck, mosi, miso, ss_n
    );
    modport peer (
        output peer_sck, peer_sck_oe, peer_mosi, peer_mosi_oe,
        output peer_ss_n, peer_ss_oe, peer_miso, peer_miso_oe,
        input sck, mosi, miso, ss_n
    );
endinterface : spm_link_if
`default_nettype wire

//--- src/spm_peer.sv
// partner end of the serial link: simple master or slave shifter
// assumes: link pins synchronous to clk_i, one byte per start pulse
`timescale 1ns/1ns
`default_nettype none
module spm_peer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic master_i,
    input wire logic clock_polarity_i,
    input wire logic clock_phase_i,
    input wire logic lsb_first_i,
    input wire logic start_i,
    input wire logic [7:0] tx_byte_i,
    output logic [7:0] rx_byte_o,
    output logic done_o,
    output logic busy_o,
    spm_link_if.peer link
);
    import spm_pkg::*;

    spm_state_t state_q, state_d;
    logic [7:0] tx_q, tx_d, rx_q, rx_d, rxb_q, rxb_d;
    logic sck_q, sck_d, done_q, done_d, edge_hit, samp, in_bit, sel;
    logic [6:0] div_q, div_d;
    logic [3:0] ecnt_q, ecnt_d;
    logic [2:0] bcnt_q, bcnt_d;

    assign sel = ~master_i & ~link.ss_n;
    assign in_bit = master_i ? link.miso : link.mosi;
    assign busy_o = master_i ? (state_q == SPM_RUN) : (sel & (bcnt_q != 3'h0));

    // ------------------------------------------------------------
    // shift engine
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        tx_d = tx_q;
        rx_d = rx_q;
        rxb_d = rxb_q;
        sck_d = sck_q;
        div_d = div_q;
        ecnt_d = ecnt_q;
        bcnt_d = bcnt_q;
        done_d = 1'b0;
        edge_hit = 1'b0;
        samp = 1'b0;
        if (master_i) begin
            case (state_q)
                SPM_IDLE: begin
                    sck_d = clock_polarity_i;
                    if (start_i) begin
                        tx_d = tx_byte_i;
                        state_d = SPM_RUN;
                        div_d = 7'(PEER_HALF - 7'h01);
                        ecnt_d = 4'h0;
                        bcnt_d = 3'h0;
                    end
                end
                SPM_RUN: begin
                    if (div_q == 7'h00) begin
                        edge_hit = 1'b1;
                        div_d = 7'(PEER_HALF - 7'h01);
                        sck_d = ~sck_q;
                        samp = ~ecnt_q[0] ^ clock_phase_i;
                        ecnt_d = 4'(ecnt_q + 4'h1);
                        if (ecnt_q == LAST_EDGE) begin
                            state_d = SPM_IDLE;
                            done_d = 1'b1;
                        end
                    end else begin
                        div_d = 7'(div_q - 7'h01);
                    end
                end
                default: state_d = SPM_IDLE;
            endcase
        end else begin
            state_d = SPM_IDLE;
            sck_d = link.sck;
            if (!sel) begin
                bcnt_d = 3'h0;
            end else if (link.sck != sck_q) begin
                edge_hit = 1'b1;
                samp = (link.sck != clock_polarity_i) ^ clock_phase_i;
                if (samp && bcnt_q == LAST_BIT) begin
                    done_d = 1'b1;
                end
            end
            if (start_i && !busy_o) begin
                tx_d = tx_byte_i;
            end
        end
        if (edge_hit) begin
            if (samp) begin
                rx_d = lsb_first_i ? {in_bit, rx_q[7:1]} : {rx_q[6:0], in_bit};
                bcnt_d = 3'(bcnt_q + 3'h1);
            end else if (!(clock_phase_i && bcnt_q == 3'h0)) begin
                tx_d = lsb_first_i ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
            end
        end
        if (done_d) begin
            rxb_d = rx_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= SPM_IDLE;
            tx_q <= RST_DATA;
            rx_q <= RST_DATA;
            rxb_q <= RST_DATA;
            sck_q <= 1'b0;
            div_q <= 7'h00;
            ecnt_q <= 4'h0;
            bcnt_q <= 3'h0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            rxb_q <= rxb_d;
            sck_q <= sck_d;
            div_q <= div_d;
            ecnt_q <= ecnt_d;
            bcnt_q <= bcnt_d;
            done_q <= done_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rx_byte_o = rxb_q;
    assign done_o = done_q;
    assign link.peer_sck = sck_q;
    assign link.peer_sck_oe = master_i;
    assign link.peer_mosi = lsb_first_i ? tx_q[0] : tx_q[7];
    assign link.peer_mosi_oe = master_i;
    // select held one clock past the last edge so a synchronous slave sees it
    assign link.peer_ss_n = ~(state_q == SPM_RUN || done_q);
    assign link.peer_ss_oe = master_i;
    assign link.peer_miso = lsb_first_i ? tx_q[0] : tx_q[7];
    assign link.peer_miso_oe = sel;
endmodule : spm_peer
`default_nettype wire

//--- src/spm_pkg.sv
// constants shared by both ends of the byte-wide serial port
// assumes: one 20 MHz clock and a synchronous active-high reset at each end
package spm_pkg;
    // ------------------------------------------------------------
    // register map, word index times four gives the byte address
    // ------------------------------------------------------------
    localparam int ADR_W = 12;
    localparam logic [7:0] IDX_STATUS = 8'hAA;
    localparam logic [7:0] IDX_CONTROL = 8'hD5;
    localparam logic [7:0] IDX_DATA = 8'hB0;
    localparam logic [7:0] IDX_MASK = 8'hB1;
    localparam logic [7:0] IDX_CONFIG = 8'hB2;
    localparam logic [ADR_W-1:0] ADR_STATUS = {2'b00, IDX_STATUS, 2'b00};
    localparam logic [ADR_W-1:0] ADR_CONTROL = {2'b00, IDX_CONTROL, 2'b00};
    localparam logic [ADR_W-1:0] ADR_DATA = {2'b00, IDX_DATA, 2'b00};
    localparam logic [ADR_W-1:0] ADR_MASK = {2'b00, IDX_MASK, 2'b00};
    localparam logic [ADR_W-1:0] ADR_CONFIG = {2'b00, IDX_CONFIG, 2'b00};
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_TRANSFER_IRQ_ENABLE = 7;
    localparam int CTRL_PORT_ENABLE = 6;
    localparam int CTRL_BIT_ORDER_SELECT = 5;
    localparam int CTRL_MASTER_SELECT = 4;
    localparam int CTRL_CLOCK_POLARITY = 3;
    localparam int CTRL_CLOCK_PHASE = 2;
    localparam int STAT_TRANSFER_DONE = 7;
    localparam int STAT_WRITE_COLLISION = 6;
    localparam int MASK_SYSTEM_SERIAL_IRQ_ENABLE = 7;
    localparam int CFG_TWELVE_CLOCK = 0;
    localparam logic [7:0] STAT_IMPL_BITS = 8'hC0;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;
    // ------------------------------------------------------------
    // sck half periods in clocks: divider / 2, by rate code
    // ------------------------------------------------------------
    localparam logic [6:0] HALF_SIX [0:3] = '{7'h01, 7'h04, 7'h10, 7'h20};
    localparam logic [6:0] HALF_TWELVE [0:3] = '{7'h02, 7'h08, 7'h20, 7'h40};
    localparam logic [6:0] PEER_HALF = 7'h04;
    localparam logic [3:0] LAST_EDGE = 4'hF;
    localparam logic [2:0] LAST_BIT = 3'h7;
    typedef enum logic [1:0] {
        SPM_IDLE = 2'b01,
        SPM_RUN = 2'b10
    } spm_state_t;
endpackage : spm_pkg

//--- src/spm_port.sv
// serial port end: wishbone register slave plus master/slave shift engine
// assumes: link pins synchronous to clk_i, classic wishbone master
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module spm_port (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [spm_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    spm_link_if.dev link
);
    import spm_pkg::*;

    logic [7:0] ctrl_q, ctrl_d, stat_q, stat_d, mask_q, mask_d, cfg_q, cfg_d;
    logic [7:0] rxbuf_q, rxbuf_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    spm_state_t state_q, state_d;
    logic [7:0] tx_q, tx_d, rx_q, rx_d;
    logic sck_q, sck_d;
    logic [6:0] div_q, div_d, half;
    logic [3:0] ecnt_q, ecnt_d;
    logic [2:0] bcnt_q, bcnt_d;
    logic pend_q, pend_d;
    logic wb_req, wr_go, data_wr, busy, done, port_en, is_master, lsb_first;
    logic clock_polarity, clock_phase, slave_sel, edge_hit, samp, in_bit;
    logic [1:0] rate;

    assign port_en = ctrl_q[CTRL_PORT_ENABLE];
    assign is_master = ctrl_q[CTRL_MASTER_SELECT];
    assign lsb_first = ctrl_q[CTRL_BIT_ORDER_SELECT];
    assign clock_polarity = ctrl_q[CTRL_CLOCK_POLARITY];
    assign clock_phase = ctrl_q[CTRL_CLOCK_PHASE];
    assign rate = ctrl_q[1:0];
    assign wb_req = wb_cyc_i & wb_stb_i;
    // a write commits at the edge where the master sees ack
    assign wr_go = wb_req & wb_we_i & ack_q & wb_sel_i[0];
    assign data_wr = wr_go & (wb_adr_i == ADR_DATA);
    assign slave_sel = port_en & ~is_master & ~link.ss_n;
    assign busy = is_master ? ((state_q == SPM_RUN) | pend_q) : (slave_sel & (bcnt_q != 3'h0));
    assign in_bit = is_master ? link.miso : link.mosi;

    // ------------------------------------------------------------
    // shift engine
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        tx_d = tx_q;
        rx_d = rx_q;
        sck_d = sck_q;
        div_d = div_q;
        ecnt_d = ecnt_q;
        bcnt_d = bcnt_q;
        pend_d = 1'b0;
        done = 1'b0;
        edge_hit = 1'b0;
        samp = 1'b0;
        half = cfg_q[CFG_TWELVE_CLOCK] ? HALF_TWELVE[rate] : HALF_SIX[rate];
        if (!port_en) begin
            state_d = SPM_IDLE;
            sck_d = clock_polarity;
            ecnt_d = 4'h0;
            bcnt_d = 3'h0;
        end else if (is_master) begin
            case (state_q)
                SPM_IDLE: begin
                    sck_d = clock_polarity;
                    // last trailing-edge bit lands one clock after the clock stops
                    done = pend_q;
                    if (data_wr && !busy) begin
                        tx_d = wb_dat_i[7:0];
                        state_d = SPM_RUN;
                        div_d = 7'(half - 7'h01);
                        ecnt_d = 4'h0;
                        bcnt_d = 3'h0;
                    end
                end
                SPM_RUN: begin
                    if (div_q == 7'h00) begin
                        edge_hit = 1'b1;
                        div_d = 7'(half - 7'h01);
                        sck_d = ~sck_q;
                        samp = ~ecnt_q[0] ^ clock_phase;
                        pend_d = samp;
                        ecnt_d = 4'(ecnt_q + 4'h1);
                        if (ecnt_q == LAST_EDGE) begin
                            state_d = SPM_IDLE;
                            done = ~clock_phase;
                        end
                    end else begin
                        div_d = 7'(div_q - 7'h01);
                    end
                end
                default: state_d = SPM_IDLE;
            endcase
        end else begin
            state_d = SPM_IDLE;
            sck_d = link.sck;
            if (!slave_sel) begin
                bcnt_d = 3'h0;
            end else if (link.sck != sck_q) begin
                edge_hit = 1'b1;
                samp = (link.sck != clock_polarity) ^ clock_phase;
                if (samp && bcnt_q == LAST_BIT) begin
                    done = 1'b1;
                end
            end
            if (data_wr && !busy) begin
                tx_d = wb_dat_i[7:0];
            end
        end
        // master takes miso a clock after its edge: a synchronous partner answers late
        if ((edge_hit && samp && !is_master) || (pend_q && is_master)) begin
            rx_d = lsb_first ? {in_bit, rx_q[7:1]} : {rx_q[6:0], in_bit};
            bcnt_d = 3'(bcnt_q + 3'h1);
        end
        if (edge_hit && !samp && !(clock_phase && (is_master ? ecnt_q == 4'h0 : bcnt_q == 3'h0))) begin
            // first bit is already on the pin before the first drive edge
            tx_d = lsb_first ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= SPM_IDLE;
            tx_q <= RST_DATA;
            rx_q <= RST_DATA;
            sck_q <= 1'b0;
            div_q <= 7'h00;
            ecnt_q <= 4'h0;
            bcnt_q <= 3'h0;
            pend_q <= 1'b0;
        end else begin
            state_q <= state_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            sck_q <= sck_d;
            div_q <= div_d;
            ecnt_q <= ecnt_d;
            bcnt_q <= bcnt_d;
            pend_q <= pend_d;
        end
    end

    // ------------------------------------------------------------
    // registers and bus slave
    // ------------------------------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        cfg_d = cfg_q;
        rxbuf_d = done ? rx_d : rxbuf_q;
        stat_d = stat_q;
        ack_d = wb_req & ~ack_q;
        rdat_d = rdat_q;
        if (wr_go) begin
            case (wb_adr_i)
                ADR_CONTROL: ctrl_d = wb_dat_i[7:0];
                // write one clears; unused bits are simply ignored
                ADR_STATUS: stat_d = stat_q & ~(wb_dat_i[7:0] & STAT_IMPL_BITS);
                ADR_MASK: mask_d = wb_dat_i[7:0] & STAT_IMPL_BITS;
                ADR_CONFIG: cfg_d = {7'h00, wb_dat_i[CFG_TWELVE_CLOCK]};
                default: ;
            endcase
        end
        // set beats a clear arriving in the same cycle
        if (done) begin
            stat_d[STAT_TRANSFER_DONE] = 1'b1;
        end
        if (data_wr && busy) begin
            stat_d[STAT_WRITE_COLLISION] = 1'b1;
        end
        if (ack_d) begin
            case (wb_adr_i)
                ADR_CONTROL: rdat_d = {24'h000000, ctrl_q};
                ADR_STATUS: rdat_d = {24'h000000, stat_q};
                ADR_DATA: rdat_d = {24'h000000, rxbuf_q};
                ADR_MASK: rdat_d = {24'h000000, mask_q};
                ADR_CONFIG: rdat_d = {24'h000000, cfg_q};
                default: rdat_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= RST_CONTROL;
            stat_q <= RST_STATUS;
            mask_q <= RST_MASK;
            cfg_q <= RST_CONFIG;
            rxbuf_q <= RST_DATA;
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ctrl_q <= ctrl_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            cfg_q <= cfg_d;
            rxbuf_q <= rxbuf_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign irq_o = (stat_q[STAT_TRANSFER_DONE] & ctrl_q[CTRL_TRANSFER_IRQ_ENABLE]
                    & mask_q[MASK_SYSTEM_SERIAL_IRQ_ENABLE])
                   | (stat_q[STAT_WRITE_COLLISION] & mask_q[STAT_WRITE_COLLISION]);
    assign link.dev_sck = sck_q;
    assign link.dev_sck_oe = port_en & is_master;
    assign link.dev_mosi = lsb_first ? tx_q[0] : tx_q[7];
    assign link.dev_mosi_oe = port_en & is_master;
    // select held while the last bit is taken, so the slave still drives it
    assign link.dev_ss_n = ~(state_q == SPM_RUN || pend_q);
    assign link.dev_ss_oe = port_en & is_master;
    assign link.dev_miso = lsb_first ? tx_q[0] : tx_q[7];
    assign link.dev_miso_oe = slave_sel;
endmodule : spm_port
`default_nettype wire

//--- tb/spm_chk.sv
// link checks between the two port ends, fed from the link interface
// assumes: one clock domain, instantiated beside the interface
`timescale 1ns/1ns
`default_nettype none
module spm_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sck,
    input wire logic mosi,
    input wire logic ss_n,
    input wire logic dev_sck_oe,
    input wire logic dev_miso_oe,
    input wire logic peer_sck_oe,
    input wire logic peer_miso_oe
);
    logic [4:0] edge_q, edge_d;
    logic [10:0] low_q, low_d;
    logic sck_q, ss_q, idle_q, idle_d;
    // ------------------------------------------------------------
    // frame bookkeeping
    // ------------------------------------------------------------
    always_comb begin
        edge_d = (sck != sck_q) ? edge_q + 5'd1 : edge_q;
        idle_d = idle_q;
        if (ss_q && !ss_n) begin
            // an edge in the select cycle still belongs to the frame
            edge_d = (sck != sck_q) ? 5'd1 : 5'd0;
            idle_d = sck_q;
        end
        low_d = ss_n ? 11'd0 : low_q + 11'd1;
    end
    always_ff @(posedge clk_i) begin
        sck_q <= sck;
        ss_q <= ss_n;
        if (rst_i) begin
            edge_q <= 5'd0;
            low_q <= 11'd0;
            idle_q <= 1'b0;
        end else begin
            edge_q <= edge_d;
            low_q <= low_d;
            idle_q <= idle_d;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_frame_end;
        $rose(ss_n) ##2 1'b1;
    endsequence
    sequence s_low_run;
        (!ss_n) [*7];
    endsequence
    a_edge_count: assert property (s_frame_end |-> edge_q == 5'd16)
        else $error("frame did not carry sixteen clock edges");
    a_idle_level: assert property (s_frame_end |-> sck == idle_q)
        else $error("clock left at a different idle level");
    a_frame_min: assert property ($fell(ss_n) |-> s_low_run ##1 s_low_run)
        else $error("frame shorter than one byte");
    // slowest divider is 128, so a byte never needs more than 1026 clocks
    a_frame_max: assert property (low_q <= 11'd1026)
        else $error("frame longer than the slowest rate allows");
    a_mosi_on_edge: assert property (
        $changed(mosi) && !ss_n && !$past(ss_n) && dev_sck_oe |-> $changed(sck))
        else $error("data line moved between clock edges");
    a_one_driver: assert property (!(dev_sck_oe && peer_sck_oe))
        else $error("both ends drive the clock");
    a_dev_roles: assert property (dev_sck_oe |-> !dev_miso_oe)
        else $error("port drives clock and slave data together");
    a_peer_roles: assert property (peer_sck_oe |-> !peer_miso_oe)
        else $error("partner drives clock and slave data together");
endmodule : spm_chk
`default_nettype wire

//--- tb/spm_port_tb_top.sv
// self-checking bench: register port end facing the partner end
// assumes: both ends share clk_i, wishbone driven from this module
`timescale 1ns/1ns
`default_nettype none
module spm_port_tb_top;
    import spm_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [31:0] dat = '0;
    logic [31:0] rdat;
    logic ack, irq, p_done;
    logic p_mst = 1'b0;
    logic p_pol = 1'b0;
    logic p_pha = 1'b0;
    logic p_lsb = 1'b0;
    logic p_go = 1'b0;
    logic [7:0] p_tx = 8'h00;
    logic [7:0] p_rx, rd;
    logic sck_p = 1'b1;
    int err_count = 0;
    int tests_run = 0;
    int cyc_n = 0;
    int last_e = 0;
    int gap = 0;
    spm_link_if lk();
    spm_port spm_port_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq_o(irq), .link(lk.dev));
    spm_peer spm_peer_i (.clk_i(clk_i), .rst_i(rst_i), .master_i(p_mst), .clock_polarity_i(p_pol),
        .clock_phase_i(p_pha), .lsb_first_i(p_lsb), .start_i(p_go), .tx_byte_i(p_tx),
        .rx_byte_o(p_rx), .done_o(p_done), .busy_o(), .link(lk.peer));
    spm_chk spm_chk_i (.clk_i(clk_i), .rst_i(rst_i), .sck(lk.sck), .mosi(lk.mosi),
        .ss_n(lk.ss_n), .dev_sck_oe(lk.dev_sck_oe), .dev_miso_oe(lk.dev_miso_oe),
        .peer_sck_oe(lk.peer_sck_oe), .peer_miso_oe(lk.peer_miso_oe));
    always #25 clk_i = ~clk_i;
    // ------------------------------------------------------------
    // half period of the link clock, seen on the wire
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        sck_p <= lk.sck;
        if (lk.sck !== sck_p && lk.ss_n === 1'b0) begin
            gap <= cyc_n - last_e;
            last_e <= cyc_n;
        end
    end
    // ------------------------------------------------------------
    // reporting and bus tasks
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task automatic fail(input string s);
        err_count++;
        $display("unexpected at %0t: %s", $time, s);
        summarize();
    endtask : fail
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string s);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
        end
    endtask : chk
    task automatic chk_bit(input logic got, input logic exp, input string s);
        chk({7'h00, got}, {7'h00, exp}, s);
    endtask : chk_bit
    // ends on a falling edge so that combinational outputs have settled
    task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) fail("bus ack missing");
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(negedge clk_i);
    endtask : wb
    task automatic rchk(input logic [ADR_W-1:0] a, input logic [7:0] e, input string s);
        wb(1'b0, a, 8'h00);
        chk(rd, e, s);
    endtask : rchk
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            wb(1'b0, ADR_STATUS, 8'h00);
            n++;
        end while (rd[STAT_TRANSFER_DONE] !== 1'b1 && n < 400);
        if (n >= 400) fail("done flag never set");
    endtask : wait_done
    task automatic go_peer(input logic m, input logic [7:0] ctl, input logic [7:0] tx);
        @(posedge clk_i);
        p_mst <= m;
        p_pol <= ctl[CTRL_CLOCK_POLARITY];
        p_pha <= ctl[CTRL_CLOCK_PHASE];
        p_lsb <= ctl[CTRL_BIT_ORDER_SELECT];
        p_tx <= tx;
        @(posedge clk_i);
        p_go <= 1'b1;
        @(posedge clk_i);
        p_go <= 1'b0;
    endtask : go_peer
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rchk(ADR_CONTROL, 8'h00, "control reset");
        rchk(ADR_STATUS, 8'h00, "status reset");
        rchk(12'h004, 8'h00, "unmapped read");
        wb(1'b1, ADR_CONTROL, 8'h3F);
        rchk(ADR_CONTROL, 8'h3F, "control readback");
        wb(1'b1, ADR_STATUS, 8'hC0);
        rchk(ADR_STATUS, 8'h00, "status not writable");
        wb(1'b1, ADR_CONTROL, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_master(input logic [7:0] ctl, input logic twelve, input logic [7:0] dtx,
        input logic [7:0] ptx);
        int h;
        h = (twelve ? 2 : 1) * (ctl[1:0] == 2'b00 ? 1 : ctl[1:0] == 2'b01 ? 4 :
            ctl[1:0] == 2'b10 ? 16 : 32);
        go_peer(1'b0, ctl, ptx);
        wb(1'b1, ADR_CONFIG, {7'h00, twelve});
        wb(1'b1, ADR_MASK, 8'h80);
        wb(1'b1, ADR_CONTROL, ctl);
        chk_bit(irq, 1'b0, "irq before transfer");
        wb(1'b1, ADR_DATA, dtx);
        wait_done();
        chk(rd, 8'h80, "status after transfer");
        chk_bit(irq, 1'b1, "irq after transfer");
        chk(8'(gap), 8'(h), "clock half period");
        chk(p_rx, dtx, "partner received");
        rchk(ADR_DATA, ptx, "port received");
        wb(1'b1, ADR_MASK, 8'h00);
        chk_bit(irq, 1'b0, "irq system masked");
        wb(1'b1, ADR_STATUS, 8'h80);
        rchk(ADR_STATUS, 8'h00, "done cleared");
        $display("test master %h done", ctl);
    endtask : t_master
    task automatic t_coll();
        go_peer(1'b0, 8'h00, 8'h69);
        wb(1'b1, ADR_CONFIG, 8'h00);
        wb(1'b1, ADR_MASK, 8'h80);
        wb(1'b1, ADR_CONTROL, 8'h53);
        wb(1'b1, ADR_DATA, 8'h96);
        wb(1'b1, ADR_DATA, 8'h55);
        wait_done();
        chk(rd, 8'hC0, "collision status");
        chk_bit(irq, 1'b0, "irq local disable");
        wb(1'b1, ADR_MASK, 8'h40);
        chk_bit(irq, 1'b1, "irq on collision");
        chk(p_rx, 8'h96, "byte kept");
        wb(1'b1, ADR_STATUS, 8'h40);
        rchk(ADR_STATUS, 8'h80, "collision cleared alone");
        wb(1'b1, ADR_STATUS, 8'h80);
        rchk(ADR_STATUS, 8'h00, "all cleared");
        $display("test collision done");
    endtask : t_coll
    task automatic t_slave(input logic [7:0] ctl, input logic [7:0] dtx, input logic [7:0] ptx);
        int n;
        n = 0;
        wb(1'b1, ADR_CONTROL, ctl);
        wb(1'b1, ADR_DATA, dtx);
        chk_bit(lk.dev_sck_oe, 1'b0, "slave clock released");
        rchk(ADR_STATUS, 8'h00, "slave unselected");
        go_peer(1'b1, ctl, ptx);
        while (p_done !== 1'b1 && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 1000) fail("partner never finished");
        wait_done();
        chk(rd, 8'h80, "slave done");
        chk(p_rx, dtx, "partner received");
        rchk(ADR_DATA, ptx, "slave received");
        wb(1'b1, ADR_STATUS, 8'h80);
        $display("test slave %h done", ctl);
    endtask : t_slave
    task automatic t_off();
        go_peer(1'b0, 8'h00, 8'h00);
        wb(1'b1, ADR_CONTROL, 8'h10);
        wb(1'b1, ADR_DATA, 8'h77);
        repeat (40) @(posedge clk_i);
        rchk(ADR_STATUS, 8'h00, "disabled idle");
        chk_bit(lk.dev_sck_oe, 1'b0, "disabled clock");
        $display("test disabled done");
    endtask : t_off
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        for (int m = 0; m < 4; m++) begin
            t_master({2'b11, m[0], 1'b1, m[1], m[0], m[1:0]}, 1'b0, 8'hA1 + 8'(m * 19),
                8'h1E ^ 8'(m));
        end
        t_master(8'hF1, 1'b1, 8'h2B, 8'hE6);
        t_coll();
        t_slave(8'h4F, 8'h4D, 8'hB4);
        t_slave(8'h60, 8'h2C, 8'h71);
        t_off();
        summarize();
    end
endmodule : spm_port_tb_top
`default_nettype wire
